/* File: rtl/cmpc_top.sv */
// Comparator control block: registers, input routing, result path and pin forcing
// Functional notes
// - The minus input comes from one of six sources picked by control bits 3 to 1, 000 being input a and 011 the ladder.
// - Control bit 0 picks the plus input, 0 for the ladder and 1 for input b.
// - Control bit 7 enables the comparator; while it is 0 the comparator stays off.
// - Select bit 7 forces the result onto the compare output pin whatever its direction.
// - The result is offered either directly or sampled by the secondary timer clock.
// - Control bit 4 inverts the result before the status bit, the interrupt request and the pin.
// - Select bits 5 and 4 choose one of four ladder ranges, 00 giving 1/32 and 10 giving 1/40 steps.
// - Select bits 3 to 0 pick one of sixteen equally spaced ladder taps within that range.
`include "cmpc_defs.svh"

module cmpc_top
  import cmpc_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Register port
  input wire logic [`CMPC_ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Analog comparator macro
  input wire logic CMP_RAW_I,
  output cmpc_analog_t ANALOG_O,
  output cmpc_ratio_t LADDER_RATIO_O,
  // Secondary timer clock
  input wire logic TMR_CLK_I,
  // Compare output pin and interrupt request
  output logic PIN_O,
  output logic PIN_OE_O,
  output logic IRQ_REQ_O,
  output logic RESULT_O
);

  // ==========================================================
  // Helpers
  function automatic logic [5:0] minus_decode(input cmpc_minus_t code);
    logic [5:0] oh;
    oh = 6'h00;
    case (code)
      CMPC_MIN_IN_A: oh = 6'h01;
      CMPC_MIN_IN_B: oh = 6'h02;
      CMPC_MIN_BANDGAP: oh = 6'h04;
      CMPC_MIN_LADDER: oh = 6'h08;
      CMPC_MIN_IN_C: oh = 6'h10;
      CMPC_MIN_IN_D: oh = 6'h20;
      default: oh = 6'h00;
    endcase
    return oh;
  endfunction

  // Ranges 00 and 10 start at nine steps above ground, 01 and 11 at one
  function automatic cmpc_ratio_t ladder_ratio(input logic [1:0] range, input logic [3:0] tap);
    cmpc_ratio_t r;
    r.num = {2'b00, tap} + (range[0] ? `CMPC_LAD_OFS_LO : `CMPC_LAD_OFS_HI);
    case (range)
      2'b00: r.den = `CMPC_LAD_DEN_R0;
      2'b01: r.den = `CMPC_LAD_DEN_R1;
      2'b10: r.den = `CMPC_LAD_DEN_R2;
      default: r.den = `CMPC_LAD_DEN_R3;
    endcase
    return r;
  endfunction

  // Address compare shared by the write and read decoders
  function automatic logic reg_hit(input logic [`CMPC_ADDR_W-1:0] addr, input logic [`CMPC_ADDR_W-1:0] off);
    return (addr == off);
  endfunction

  // ==========================================================
  // Registers
  cmpc_ctrl_t ctrl_q;
  cmpc_sel_t sel_q;
  logic result_q;
  logic irq_q;
  logic [7:0] rdata_q;
  cmpc_analog_t analog_q;
  cmpc_ratio_t ratio_q;

  // ==========================================================
  // Address decoding
  wire hit_ctrl_w;
  wire hit_sel_w;
  wire wr_ctrl_w;
  wire wr_sel_w;
  wire [7:0] ctrl_wr_w;
  logic [7:0] rd_mux_w;

  assign hit_ctrl_w = reg_hit(ADDR_I, `CMPC_OFF_CTRL);
  assign hit_sel_w = reg_hit(ADDR_I, `CMPC_OFF_SEL);
  assign wr_ctrl_w = WR_I & hit_ctrl_w;
  assign wr_sel_w = WR_I & hit_sel_w;
  // Result and spare bits never take write data
  assign ctrl_wr_w = WDATA_I & `CMPC_CTRL_WMASK;

  // ==========================================================
  // Read images; bit 6 of control shows the live result
  wire [7:0] ctrl_img_w;
  wire [7:0] sel_img_w;

  assign ctrl_img_w = {ctrl_q.enable, result_q, 1'b0, ctrl_q.invert, ctrl_q.minus_sel, ctrl_q.plus_sel};
  assign sel_img_w = sel_q;

  always_comb begin
    if (hit_ctrl_w) begin
      rd_mux_w = ctrl_img_w;
    end else if (hit_sel_w) begin
      rd_mux_w = sel_img_w;
    end else begin
      rd_mux_w = 8'h00;
    end
  end

  // ==========================================================
  // Register writes; the result bit and bit 5 are not writable
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= cmpc_ctrl_t'(`CMPC_CTRL_RST);
      sel_q <= cmpc_sel_t'(`CMPC_SEL_RST);
    end else if (CE_I) begin
      if (wr_ctrl_w) begin
        ctrl_q <= cmpc_ctrl_t'(ctrl_wr_w);
      end
      if (wr_sel_w) begin
        sel_q <= cmpc_sel_t'(WDATA_I);
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= 8'h00;
    end else if (CE_I) begin
      rdata_q <= RD_I ? rd_mux_w : 8'h00;
    end
  end

  // ==========================================================
  // Analog steering
  cmpc_analog_t analog_d;
  cmpc_ratio_t ratio_d;

  always_comb begin
    analog_d.enable = ctrl_q.enable;
    analog_d.minus_onehot = minus_decode(ctrl_q.minus_sel);
    analog_d.plus_pin = ctrl_q.plus_sel;
    analog_d.range = sel_q.range;
    analog_d.tap = sel_q.tap;
    ratio_d = ladder_ratio(sel_q.range, sel_q.tap);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      analog_q <= '0;
      ratio_q <= '0;
    end else if (CE_I) begin
      analog_q <= analog_d;
      ratio_q <= ratio_d;
    end
  end

  // ==========================================================
  // Result path; a disabled comparator reads as a low raw output
  wire raw_w;
  wire pol_w;
  wire sampled_w;
  wire chosen_w;

  assign raw_w = CMP_RAW_I & ctrl_q.enable;
  assign pol_w = raw_w ^ ctrl_q.invert;

  cmpc_sampler u_sampler (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .tmr_clk_i(TMR_CLK_I),
    .res_i(pol_w),
    .sampled_o(sampled_w)
  );

  // Sampled results lag the timer edge by four system clocks
  assign chosen_w = sel_q.sample_mode ? sampled_w : pol_w;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      result_q <= 1'b0;
    end else if (CE_I) begin
      result_q <= chosen_w;
    end
  end

  // ==========================================================
  // Interrupt request; a one-cycle pulse per rising result, latched by the interrupt controller
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_q <= 1'b0;
    end else if (CE_I) begin
      irq_q <= chosen_w & ~result_q;
    end
  end

  // ==========================================================
  // Outputs; forcing overrides the pin direction set elsewhere
  assign RDATA_O = rdata_q;
  assign ANALOG_O = analog_q;
  assign LADDER_RATIO_O = ratio_q;
  assign PIN_O = result_q & sel_q.force_out;
  assign PIN_OE_O = sel_q.force_out;
  assign IRQ_REQ_O = irq_q;
  assign RESULT_O = result_q;

endmodule // cmpc_top

/* File: rtl/cmpc_defs.svh */
// Offsets, field positions, reset values and ladder constants of the comparator control block
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

// ==========================================================
// Register offsets
`define CMPC_ADDR_W 4
`define CMPC_OFF_CTRL 4'h0
`define CMPC_OFF_SEL 4'h1

// ==========================================================
// Control register fields
`define CMPC_CTRL_PLUS 0
`define CMPC_CTRL_MINUS_LO 1
`define CMPC_CTRL_MINUS_HI 3
`define CMPC_CTRL_INV 4
`define CMPC_CTRL_RES 6
`define CMPC_CTRL_EN 7
`define CMPC_CTRL_RST 8'h00
`define CMPC_CTRL_WMASK 8'h9f

// ==========================================================
// Select register fields
`define CMPC_SEL_TAP_LO 0
`define CMPC_SEL_TAP_HI 3
`define CMPC_SEL_RANGE_LO 4
`define CMPC_SEL_RANGE_HI 5
`define CMPC_SEL_SAMPLE 6
`define CMPC_SEL_FORCE 7
`define CMPC_SEL_RST 8'h00

// ==========================================================
// Ladder tap ratio: level = (tap + offset) / denominator of the supply
`define CMPC_LAD_OFS_HI 6'h09
`define CMPC_LAD_OFS_LO 6'h01
`define CMPC_LAD_DEN_R0 6'h20
`define CMPC_LAD_DEN_R1 6'h18
`define CMPC_LAD_DEN_R2 6'h28
`define CMPC_LAD_DEN_R3 6'h20

`endif

/* File: rtl/cmpc_pkg.sv */
// Types shared by the comparator control block
package cmpc_pkg;

  // ==========================================================
  // Minus input sources, in field code order
  typedef enum logic [2:0] {
    CMPC_MIN_IN_A,
    CMPC_MIN_IN_B,
    CMPC_MIN_BANDGAP,
    CMPC_MIN_LADDER,
    CMPC_MIN_IN_C,
    CMPC_MIN_IN_D,
    CMPC_MIN_RSV6,
    CMPC_MIN_RSV7
  } cmpc_minus_t;

  // ==========================================================
  // Register images
  typedef struct packed {
    logic enable;
    logic result;
    logic spare;
    logic invert;
    cmpc_minus_t minus_sel;
    logic plus_sel;
  } cmpc_ctrl_t;

  typedef struct packed {
    logic force_out;
    logic sample_mode;
    logic [1:0] range;
    logic [3:0] tap;
  } cmpc_sel_t;

  // ==========================================================
  // Analog steering towards the comparator macro
  typedef struct packed {
    logic enable;
    logic [5:0] minus_onehot;
    logic plus_pin;
    logic [1:0] range;
    logic [3:0] tap;
  } cmpc_analog_t;

  // Ladder level as a fraction of the supply
  typedef struct packed {
    logic [5:0] num;
    logic [5:0] den;
  } cmpc_ratio_t;

endpackage : cmpc_pkg

/* File: rtl/cmpc_sampler.sv */
// Samples the comparator result on rising edges of the secondary timer clock
module cmpc_sampler
  import cmpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Sampling clock and data
  input wire logic tmr_clk_i,
  input wire logic res_i,
  output logic sampled_o
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic sampled_q;
  wire rise_w;

  // ==========================================================
  // Synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= tmr_clk_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign rise_w = sync2_q & ~sync3_q;

  // ==========================================================
  // Hold between timer edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sampled_q <= 1'b0;
    end else if (ce_i && rise_w) begin
      sampled_q <= res_i;
    end
  end

  assign sampled_o = sampled_q;

endmodule // cmpc_sampler

/* File: tb/cmpc_top_chk.sv */
// Port-level checker for the comparator control block
`include "cmpc_defs.svh"

module cmpc_top_chk
  import cmpc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Register port
  input wire logic [`CMPC_ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  // Comparator side and pins
  input wire logic CMP_RAW_I,
  input wire cmpc_analog_t ANALOG_O,
  input wire cmpc_ratio_t LADDER_RATIO_O,
  input wire logic TMR_CLK_I,
  input wire logic PIN_O,
  input wire logic PIN_OE_O,
  input wire logic IRQ_REQ_O,
  input wire logic RESULT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Shadow registers, so result checks know enable, invert and mode
  logic [7:0] ctrl_q;
  logic [7:0] sel_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= 8'h00;
      sel_q <= 8'h00;
    end else if (CE_I && WR_I) begin
      if (ADDR_I == 4'h0) ctrl_q <= WDATA_I & 8'h9f;
      if (ADDR_I == 4'h1) sel_q <= WDATA_I;
    end
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_wc; WR_I && CE_I && ADDR_I == 4'h0 ##1 CE_I; endsequence
  sequence s_ws; WR_I && CE_I && ADDR_I == 4'h1 ##1 CE_I; endsequence

  // ==========
  // Properties
  property p_minus;
    s_wc |-> ##1 ANALOG_O.minus_onehot ==
      (($past(WDATA_I[3:1], 2) < 3'h6) ? (6'h01 << $past(WDATA_I[3:1], 2)) : 6'h00);
  endproperty
  a_minus: assert property (p_minus) else $error("minus steering wrong");
  property p_plus_en;
    s_wc |-> ##1 {ANALOG_O.enable, ANALOG_O.plus_pin} == {$past(WDATA_I[7], 2), $past(WDATA_I[0], 2)};
  endproperty
  a_plus_en: assert property (p_plus_en) else $error("plus or enable wrong");
  property p_oe;
    s_ws |-> PIN_OE_O == $past(WDATA_I[7]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin force enable wrong");
  property p_pin;
    PIN_O == (RESULT_O && PIN_OE_O);
  endproperty
  a_pin: assert property (p_pin) else $error("pin value wrong");
  // Ratio registers in the same cycle as the steering; only judged once the tap settles
  property p_ratio;
    $past(RST_N_I) && $past(CE_I) && $stable(ANALOG_O.tap) && $stable(ANALOG_O.range) |->
      LADDER_RATIO_O.num == {2'h0, ANALOG_O.tap} + (ANALOG_O.range[0] ? 6'h01 : 6'h09) &&
      LADDER_RATIO_O.den == (ANALOG_O.range == 2'h1 ? 6'h18 : ANALOG_O.range == 2'h2 ? 6'h28 : 6'h20);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ladder ratio wrong");
  property p_direct;
    $past(RST_N_I) && $past(CE_I) && !$past(sel_q[6]) |->
      RESULT_O == (($past(CMP_RAW_I) && $past(ctrl_q[7])) ^ $past(ctrl_q[4]));
  endproperty
  a_direct: assert property (p_direct) else $error("direct result wrong");
  property p_irq;
    $past(RST_N_I) && $past(CE_I) |-> IRQ_REQ_O == $rose(RESULT_O);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");
  property p_rdc;
    RD_I && CE_I && ADDR_I == 4'h0 |=> RDATA_O == {ctrl_q[7], $past(RESULT_O), 1'b0, ctrl_q[4:0]};
  endproperty
  a_rdc: assert property (p_rdc) else $error("control readback wrong");
  property p_hold;
    (CE_I && sel_q[6] && !TMR_CLK_I && !WR_I)[*8] |-> $stable(RESULT_O);
  endproperty
  a_hold: assert property (p_hold) else $error("sampled result moved");
endmodule // cmpc_top_chk

bind cmpc_top cmpc_top_chk i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CMP_RAW_I(CMP_RAW_I),
  .ANALOG_O(ANALOG_O), .LADDER_RATIO_O(LADDER_RATIO_O), .TMR_CLK_I(TMR_CLK_I), .PIN_O(PIN_O),
  .PIN_OE_O(PIN_OE_O), .IRQ_REQ_O(IRQ_REQ_O), .RESULT_O(RESULT_O));

/* File: tb/test_cmpc_top.sv */
// Self-checking bench for the comparator control block
module test_cmpc_top
  import cmpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Stimulus and observation
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic raw = 1'b0;
  logic tmr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  cmpc_analog_t ana;
  cmpc_ratio_t rat;
  logic pin, oe, irq, res;
  int err_total = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;

  cmpc_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(we), .RD_I(re), .RDATA_O(rdata), .CMP_RAW_I(raw), .ANALOG_O(ana),
    .LADDER_RATIO_O(rat), .TMR_CLK_I(tmr), .PIN_O(pin), .PIN_OE_O(oe), .IRQ_REQ_O(irq), .RESULT_O(res));

  // ==========
  // Shared tasks
  task chk(input logic [7:0] e, input logic [7:0] g, input string n);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task bw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there
  task br(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(e, rdata, n);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========
  // Scenarios
  task t_reset;
    br(4'h0, 8'h00, "ctrl reset");
    br(4'h1, 8'h00, "sel reset");
    bw(4'h5, 8'hff);
    br(4'h5, 8'h00, "unmapped");
    br(4'h0, 8'h00, "ctrl after unmapped");
    $display("reset test done");
  endtask
  task t_route;
    for (int c = 0; c < 8; c++) begin
      bw(4'h0, {4'h8, c[2:0], c[0]});
      cy(1);
      chk(c < 6 ? 8'h01 << c : 8'h00, {2'b00, ana.minus_onehot}, "minus");
      chk({7'h01, c[0]}, {6'h00, ana.enable, ana.plus_pin}, "plus en");
      br(4'h0, {4'h8, c[2:0], c[0]}, "ctrl read");
    end
    $display("route test done");
  endtask
  task t_direct;
    for (int i = 0; i < 8; i++) begin
      bw(4'h0, {i[2], 2'b00, i[1], 4'h0});
      raw <= i[0];
      cy(3);
      chk(8'((i[2] & i[0]) ^ i[1]), 8'(res), "result");
    end
    bw(4'h0, 8'h80);
    raw <= 1'b0;
    cy(3);
    @(posedge clk);
    raw <= 1'b1;
    cy(1);
    chk(8'h03, 8'({irq, res}), "irq rise");
    cy(1);
    chk(8'h00, 8'(irq), "irq pulse");
    br(4'h0, 8'hc0, "result bit");
    $display("direct test done");
  endtask
  task t_force;
    bw(4'h1, 8'h80);
    cy(1);
    chk(8'h03, 8'({oe, pin}), "forced pin");
    @(posedge clk);
    raw <= 1'b0;
    cy(2);
    chk(8'h02, 8'({oe, pin}), "forced low");
    bw(4'h1, 8'h00);
    cy(1);
    chk(8'h00, 8'({oe, pin}), "released");
    $display("force test done");
  endtask
  task t_ladder;
    for (int r = 0; r < 4; r++) begin
      bw(4'h1, {2'b00, r[1:0], 4'(r * 5)});
      cy(2);
      chk(8'(r * 5 + (r[0] ? 1 : 9)), 8'(rat.num), "ratio num");
      chk(r == 1 ? 8'h18 : r == 2 ? 8'h28 : 8'h20, 8'(rat.den), "ratio den");
      chk({2'b00, r[1:0], 4'(r * 5)}, {2'b00, ana.range, ana.tap}, "steer tap");
      br(4'h1, {2'b00, r[1:0], 4'(r * 5)}, "sel read");
    end
    $display("ladder test done");
  endtask
  task t_sample;
    int n;
    bw(4'h1, 8'h40);
    tmr <= 1'b1;
    cy(4);
    @(posedge clk);
    tmr <= 1'b0;
    cy(8);
    @(posedge clk);
    raw <= 1'b1;
    cy(12);
    chk(8'h00, 8'(res), "held low");
    @(posedge clk);
    tmr <= 1'b1;
    for (n = 0; n < 8 && res !== 1'b1; n++) cy(1);
    if (n == 8) begin
      err_total++;
      tally_and_finish;
    end
    chk(8'h04, 8'(n), "sample latency");
    @(posedge clk);
    tmr <= 1'b0;
    raw <= 1'b0;
    cy(12);
    chk(8'h01, 8'(res), "held high");
    $display("sample test done");
  endtask
  // Supply estimate: bandgap on minus, ladder on plus, tap stepped until the result flips
  task t_supply;
    int t;
    bw(4'h0, 8'h84);
    for (t = 0; t < 16 && res !== 1'b1; t++) begin
      bw(4'h1, {4'h0, 4'(t)});
      raw <= (t >= 6); // Bandgap crosses between taps 5 and 6, analog pins have digital input off
      cy(2);
    end
    if (t == 16) begin
      err_total++;
      tally_and_finish;
    end
    chk(8'h06, 8'(t - 1), "flip tap");
    chk(8'h04, {2'b00, ana.minus_onehot}, "bandgap minus");
    br(4'h0, 8'hc4, "supply result");
    $display("supply test done");
  endtask
  // A low clock enable must freeze the result and refuse register writes
  task t_ce;
    @(posedge clk);
    ce <= 1'b0;
    raw <= 1'b0;
    bw(4'h0, 8'h00);
    cy(2);
    chk(8'h01, 8'({irq, res}), "frozen result");
    @(posedge clk);
    ce <= 1'b1;
    br(4'h0, 8'h84, "frozen ctrl");
    $display("clock enable test done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_route;
    t_direct;
    t_force;
    t_ladder;
    t_supply;
    t_ce;
    t_sample;
    tally_and_finish;
  end
endmodule // test_cmpc_top
